//--- alg_model.sv
// Purpose: algorithm side of one stream
// Assumes: engine keeps its contract
// Notes:   slow leaves every other cycle idle
`timescale 1ns/100ps
module alg_model
	import ostream_pkg::*;
(
	// clock, reset
	input wire logic        clk_sys,
	input wire logic        rst,
	// bench control
	input wire logic        go,
	input wire logic        slow,
	input wire logic [7:0]  nwords,
	output logic            busy,
	// engine lane
	input wire logic        full,
	input wire logic        done,
	output logic            valid,
	output logic            drain,
	output logic [WORD_W-1:0] data
);
	logic             act_reg = 1'b0;
	logic             gap_reg = 1'b0;
	logic             drn_reg = 1'b0;
	logic             full_q = 1'b0;
	logic             full_qq = 1'b0;
	logic [7:0]       idx_reg = 8'h0;
	logic [WORD_W-1:0] word;
	// address, byte count, then data
	assign word = idx_reg == 8'h0 ? WORD_W'(16'h1000) :
		idx_reg == 8'h1 ? WORD_W'({nwords, 4'h0}) : WORD_W'({nwords, idx_reg});
	// stop two cycles late on full; idle bus inverted
	assign valid = act_reg & ~full_qq & ~(slow & gap_reg);
	assign data = valid ? word : ~word;
	assign drain = drn_reg;
	assign busy = act_reg | drn_reg;
	// step, then hold drain with no words
	always @(posedge clk_sys) begin
		gap_reg <= ~gap_reg & ~rst;
		full_q <= full;
		full_qq <= full_q;
		if (rst) begin
			act_reg <= 1'b0;
			drn_reg <= 1'b0;
		end else if (go) begin
			act_reg <= 1'b1;
			idx_reg <= 8'h0;
		end else if (valid) begin
			idx_reg <= idx_reg + 8'h1;
			act_reg <= idx_reg <= nwords;
			drn_reg <= idx_reg == nwords + 8'h1;
		end else if (done)
			drn_reg <= 1'b0;
	end
endmodule : alg_model

//--- ostream_pkg.sv
// Purpose: shared constants and carriers for the output stream engines
// Assumes: one 40 MHz clock, synchronous active-high reset
// Notes:   payload words are 128 bits; four engines share one host port
package ostream_pkg;
	localparam int NUM_STREAMS    = 4;
	localparam int WORD_W         = 128;
	localparam int STRIDE_W       = 32;
	localparam int CLK_PERIOD_NS  = 25;
	// algorithm may keep sending this long after nearly-full rises
	localparam int GRACE_CYCLES   = 256;
	localparam int STOP_CYCLES    = 2;
	// nearly-full must leave room for the whole grace period plus slack
	localparam int BUF_DEPTH      = 512;
	localparam int NEAR_FULL_ROOM = GRACE_CYCLES + STOP_CYCLES + 2;
	localparam int HDR_WORDS      = 2;
	localparam logic [STRIDE_W-1:0] STRIDE_NO_SPLIT = 32'h0000_0000;

	// one word on the host write port
	typedef struct packed {
		logic [1:0]        stream;
		logic              is_hdr;
		logic [WORD_W-1:0] payload;
	} host_word_t;

	typedef enum logic [1:0] {
		ST_ADDR,
		ST_COUNT,
		ST_DATA,
		ST_DRAIN
	} eng_state_t;
endpackage : ostream_pkg

//--- ostream_sva.sv
// Purpose: port checks for the stream engines
// Assumes: one clock, sync reset
// Notes:   bound below
`timescale 1ns/100ps
module ostream_sva
	import ostream_pkg::*;
#(
	parameter int NSTRM = NUM_STREAMS
) (
	// clock and reset
	input wire logic                clk_sys,
	input wire logic                rst,
	// lanes
	input wire logic [NSTRM-1:0]    word_valid,
	input wire logic [NSTRM-1:0]    drain_req,
	input wire logic [NSTRM-1:0]    buf_full,
	input wire logic [NSTRM-1:0]    buf_near_full,
	input wire logic [NSTRM-1:0]    drain_done,
	input wire logic [STRIDE_W-1:0] stride [NSTRM],
	input wire logic [NSTRM-1:0]    no_split,
	// host port
	input wire logic                host_valid,
	input wire logic                host_ready
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic [NSTRM-1:0] pend_reg;
	// open requests, closed by the answer
	always_ff @(posedge clk_sys) begin
		if (rst)
			pend_reg <= '0;
		else
			pend_reg <= (pend_reg | drain_req) & ~drain_done;
	end
	property p_done_req;
		(drain_done & ~(pend_reg | drain_req)) == '0;
	endproperty
	a_done_req: assert property (p_done_req)
		else $error("done without request");
	property p_near;
		(buf_full & ~buf_near_full) == '0;
	endproperty
	a_near: assert property (p_near)
		else $error("full without near full");
	property p_full;
		$rose(buf_full[1]) |-> $past(word_valid[1]) || $past(word_valid[1], 2);
	endproperty
	a_full: assert property (p_full)
		else $error("full rose with no word");
	property p_split;
		!$past(rst) |-> no_split[1:0] ==
			{$past(stride[1]) == '0, $past(stride[0]) == '0};
	endproperty
	a_split: assert property (p_split)
		else $error("no split flag wrong");
	property p_gap;
		host_valid |=> !host_valid;
	endproperty
	a_gap: assert property (p_gap)
		else $error("host writes back to back");
	property p_ready;
		host_valid |-> $past(host_ready);
	endproperty
	a_ready: assert property (p_ready)
		else $error("host write while not ready");
endmodule : ostream_sva
bind output_stream_dma ostream_sva #(.NSTRM(NSTRM)) ostream_sva_inst (
	.clk_sys(clk_sys), .rst(rst), .word_valid(word_valid),
	.drain_req(drain_req), .buf_full(buf_full),
	.buf_near_full(buf_near_full), .drain_done(drain_done),
	.stride(stride), .no_split(no_split), .host_valid(host_valid),
	.host_ready(host_ready));

//--- output_stream_dma.sv
// Purpose: four output stream engines feeding one host write port
// Assumes: algorithm honours full/nearly-full and the drain handshake
// Notes:   host port bandwidth is split round robin over active streams
//
// Behaviour
// - four independent stream engines with own signals
// - full while buffer has two slots or fewer left
// - nearly-full leaves 256 cycles of room
// - drain-done only after request and all written
// - equal bandwidth share among active streams
// - per-stream stride, zero forbids splitting
`timescale 1ns/100ps
module output_stream_dma
	import ostream_pkg::*;
#(
	parameter int NSTRM = NUM_STREAMS,
	parameter int DEPTH = BUF_DEPTH,
	parameter int ROOM  = NEAR_FULL_ROOM
) (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	// algorithm side, one lane per stream
	input  wire logic [NSTRM-1:0]      word_valid,
	input  wire logic [WORD_W-1:0]     word_data [NSTRM],
	input  wire logic [NSTRM-1:0]      drain_req,
	output logic [NSTRM-1:0]           buf_full,
	output logic [NSTRM-1:0]           buf_near_full,
	output logic [NSTRM-1:0]           drain_done,
	// per-stream stride setting
	input  wire logic [STRIDE_W-1:0]   stride [NSTRM],
	output logic [NSTRM-1:0]           no_split,
	// host memory write port
	output logic                       host_valid,
	output host_word_t                 host_word,
	input  wire logic                  host_ready,
	input  wire logic                  host_ack
);
	localparam int CW = $clog2(DEPTH + 1);
	localparam int AW = $clog2(DEPTH);
	localparam int OW = 10;
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
	localparam logic [CW-1:0] ROOM_C  = CW'(ROOM);

	// next stream after cur with work pending, round robin
	function automatic logic [1:0] pick(input logic [NSTRM-1:0] req,
			input logic [1:0] cur);
		logic [1:0] idx;
		pick = cur;
		for (int k = NSTRM; k >= 1; k--) begin
			idx = 2'(cur + 2'(k));
			if (req[idx]) begin
				pick = idx;
			end
		end
	endfunction : pick

	logic [NSTRM-1:0] rd_valid;
	logic [NSTRM-1:0] rd_grant;
	logic [WORD_W-1:0] rd_data [NSTRM];
	logic [NSTRM-1:0] rd_hdr;
	logic [1:0]       turn_reg;
	logic [1:0]       win;
	logic             sk_ready;
	host_word_t       sk_in;
	logic             sk_out_valid;
	host_word_t       sk_out;
	logic [OW-1:0]    outstanding_reg;
	logic [OW-1:0]    out_by_strm_reg [NSTRM];

	genvar g;
	generate
		for (g = 0; g < NSTRM; g++) begin : eng
			logic [WORD_W-1:0] ram_reg [DEPTH];
			logic [AW-1:0]     wp_reg;
			logic [AW-1:0]     rp_reg;
			logic [CW-1:0]     cnt_reg;
			logic [1:0]        hdr_left_reg;
			eng_state_t        st_reg;
			logic              push;
			logic              pop;

			// a word offered while full is dropped; sender must stop
			assign push = word_valid[g] && (cnt_reg != DEPTH_C);
			assign pop  = rd_grant[g];
			assign rd_valid[g] = (cnt_reg != '0);
			assign rd_data[g]  = ram_reg[rp_reg];
			assign rd_hdr[g]   = (hdr_left_reg != 2'h0);

			// buffer storage
			always_ff @(posedge clk_sys) begin
				if (push) begin
					ram_reg[wp_reg] <= word_data[g];
				end
			end

			// pointers and fill level
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					wp_reg  <= '0;
					rp_reg  <= '0;
					cnt_reg <= '0;
				end else begin
					if (push) begin
						wp_reg <= AW'(wp_reg + 1'b1);
					end
					if (pop) begin
						rp_reg <= AW'(rp_reg + 1'b1);
					end
					cnt_reg <= CW'(cnt_reg + push - pop);
				end
			end

			// flow control flags, registered
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					buf_full[g]      <= 1'b0;
					buf_near_full[g] <= 1'b0;
				end else begin
					// two slots spare: sender may run two cycles on
					buf_full[g] <= (CW'(cnt_reg + push - pop) >=
						CW'(DEPTH_C - CW'(STOP_CYCLES)));
					buf_near_full[g] <= (CW'(cnt_reg + push - pop) >=
						CW'(DEPTH_C - ROOM_C));
				end
			end

			// header tracking: first two words of a stream are hdr
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					hdr_left_reg <= 2'(HDR_WORDS);
				end else if (drain_done[g]) begin // next stream reopens
					hdr_left_reg <= 2'(HDR_WORDS);
				end else if (pop && hdr_left_reg != 2'h0) begin
					hdr_left_reg <= 2'(hdr_left_reg - 1'b1);
				end
			end

			// stream phase and drain handshake
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					st_reg        <= ST_ADDR;
					drain_done[g] <= 1'b0;
				end else begin
					drain_done[g] <= 1'b0;
					case (st_reg)
						ST_ADDR: begin
							if (push) begin
								st_reg <= ST_COUNT;
							end
						end
						ST_COUNT: begin
							if (push) begin
								st_reg <= ST_DATA;
							end
						end
						ST_DATA: begin
							// request may share the last word's cycle
							if (drain_req[g]) begin
								st_reg <= ST_DRAIN;
							end
						end
						ST_DRAIN: begin
							// no new words expected here
							// counter covers skid, host stage and acks
							if (cnt_reg == '0 && !push &&
									out_by_strm_reg[g] == '0 &&
									!rd_grant[g]) begin
								drain_done[g] <= 1'b1;
								st_reg        <= ST_ADDR;
							end
						end
						default: st_reg <= ST_ADDR;
					endcase
				end
			end

			// stride decode
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					no_split[g] <= 1'b1;
				end else begin
					no_split[g] <= (stride[g] == STRIDE_NO_SPLIT);
				end
			end
		end
	endgenerate

	// one grant per cycle, rotating: equal share of the port
	assign win = pick(rd_valid, turn_reg);
	always_comb begin
		rd_grant = '0;
		if (sk_ready && rd_valid[win]) begin
			rd_grant[win] = 1'b1;
		end
	end
	assign sk_in = '{stream: win, is_hdr: rd_hdr[win],
		payload: rd_data[win]};

	// rotation pointer
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			turn_reg <= 2'h0;
		end else if (|rd_grant) begin
			turn_reg <= win;
		end
	end

	// host stalls are absorbed here; engines wait on sk_ready
	skid_buffer #(.WIDTH($bits(host_word_t))) u_skid (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.in_valid  (|rd_grant),
		.in_data   (sk_in),
		.in_ready  (sk_ready),
		.out_valid (sk_out_valid),
		.out_data  (sk_out),
		.out_ready (host_ready && !host_valid)
	);

	// registered host port; a word goes out for one cycle, loaded only while host_ready is high
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			host_valid <= 1'b0;
			host_word  <= '0;
		end else if (host_valid) begin
			host_valid <= 1'b0;
		end else if (sk_out_valid && host_ready) begin
			host_valid <= 1'b1;
			host_word  <= sk_out;
		end
	end

	// words granted but not yet acked, per stream, oldest-first acks
	logic [1:0] ack_strm_reg [1 << OW];
	logic [OW-1:0] aw_reg;
	logic [OW-1:0] ar_reg;
	always_ff @(posedge clk_sys) begin
		if (host_valid) begin
			ack_strm_reg[aw_reg] <= host_word.stream;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			aw_reg          <= '0;
			ar_reg          <= '0;
			outstanding_reg <= '0;
			for (int s = 0; s < NSTRM; s++) begin
				out_by_strm_reg[s] <= '0;
			end
		end else begin
			if (host_valid) begin
				aw_reg <= OW'(aw_reg + 1'b1);
			end
			if (host_ack && outstanding_reg != '0) begin
				ar_reg <= OW'(ar_reg + 1'b1);
			end
			outstanding_reg <= OW'(outstanding_reg + host_valid -
				(host_ack && outstanding_reg != '0));
			for (int s = 0; s < NSTRM; s++) begin
				out_by_strm_reg[s] <= OW'(out_by_strm_reg[s] +
					rd_grant[s] -
					(host_ack && outstanding_reg != '0 &&
					ack_strm_reg[ar_reg] == 2'(s)));
			end
		end
	end
endmodule : output_stream_dma

//--- output_stream_dma_interface_test.sv
// Purpose: self-checking bench for the stream engines
// Assumes: DEPTH 16, ROOM 6
// Notes:   host acks four cycles after each write
`timescale 1ns/100ps
module output_stream_dma_interface_test;
	import ostream_pkg::*;
	typedef struct packed {
		logic [1:0] s;
		logic [7:0] n;
		logic slow;
		logic [7:0] stall;
		logic full;
	} row_t;
	localparam row_t ROWS [4] = '{'{2'h0, 8'h03, 1'b0, 8'h00, 1'b0},
		'{2'h1, 8'h14, 1'b0, 8'h28, 1'b1}, '{2'h2, 8'h01, 1'b1, 8'h00, 1'b0},
		'{2'h3, 8'h00, 1'b0, 8'h03, 1'b0}};
	wire [3:0]           word_valid, drain_req, busy;
	logic [3:0]          buf_full, buf_near_full;
	logic [3:0]          drain_done, no_split, go, slow;
	wire [WORD_W-1:0]    word_data [4];
	logic [STRIDE_W-1:0] stride [4];
	logic [7:0]          nw [4];
	logic                clk_sys, rst, host_valid, host_ready, host_ack;
	host_word_t          host_word;
	logic [3:0]          ack_pipe = 4'h0;
	logic [1:0]          h;
	logic [1:0]          ack_q [$];
	row_t                r;
	int                  fail_count, samples_checked, sent [4], acked [4];
	output_stream_dma #(.DEPTH(16), .ROOM(6)) output_stream_dma_inst (
		.clk_sys(clk_sys), .rst(rst), .word_valid(word_valid),
		.word_data(word_data), .drain_req(drain_req), .buf_full(buf_full),
		.buf_near_full(buf_near_full), .drain_done(drain_done),
		.stride(stride), .no_split(no_split), .host_valid(host_valid),
		.host_word(host_word), .host_ready(host_ready),
		.host_ack(host_ack));
	for (genvar s = 0; s < 4; s++) begin : g_alg
		alg_model alg_model_inst (.clk_sys, .rst, .go(go[s]),
			.slow(slow[s]), .nwords(nw[s]), .busy(busy[s]),
			.full(buf_full[s]), .done(drain_done[s]),
			.valid(word_valid[s]), .drain(drain_req[s]), .data(word_data[s]));
	end
	task automatic cmp(input string nm, input logic [WORD_W-1:0] e, g);
		samples_checked++;
		if (e !== g) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize
	// bounded wait; a hang is a mismatch
	task automatic wait_for(input logic [3:0] m);
		int k;
		for (k = 0; k < 600 && (busy & m) !== 4'h0; k++)
			@(posedge clk_sys);
		#1;
		if (k == 600) begin
			fail_count++;
			summarize();
		end
	endtask : wait_for
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// acks in issue order, late so several stay open
	assign host_ack = ack_pipe[3];
	always @(posedge clk_sys)
		ack_pipe <= rst ? 4'h0 : {ack_pipe[2:0], host_valid};
	// score every host write against the stream it came from
	always @(posedge clk_sys) begin
		if (!rst && host_valid === 1'b1) begin
			h = host_word.stream;
			cmp("hdr", sent[h] < 2, host_word.is_hdr);
			cmp("payload", sent[h] == 0 ? 16'h1000 : sent[h] == 1 ?
				{nw[h], 4'h0} : {nw[h], 8'(sent[h])}, host_word.payload);
			sent[h]++;
			ack_q.push_back(h);
		end
		if (host_ack === 1'b1)
			acked[ack_q.pop_front()]++;
		for (int i = 0; i < 4; i++)
			if (drain_done[i] === 1'b1)
				cmp("acked", nw[i] + 2, acked[i]);
	end
	initial begin
		rst = 1'b1;
		host_ready = 1'b1;
		go = 4'h0;
		slow = 4'h0;
		foreach (nw[i]) nw[i] = 8'h6;
		foreach (stride[i]) stride[i] = '0;
		repeat (2) @(posedge clk_sys);
		#1 rst = 1'b0;
		cmp("no_split", 4'hf, no_split);
		foreach (ROWS[i]) begin
			r = ROWS[i];
			nw[r.s] = r.n;
			slow[r.s] = r.slow;
			host_ready = r.stall == 8'h0;
			go[r.s] = 1'b1;
			@(posedge clk_sys) #1;
			go[r.s] = 1'b0;
			repeat (r.stall) @(posedge clk_sys);
			#1;
			cmp("full", r.full, buf_full[r.s]);
			cmp("near", r.full, buf_near_full[r.s]);
			host_ready = 1'b1;
			wait_for(4'hf);
			cmp("words", r.n + 2, sent[r.s]);
			sent[r.s] = 0;
			acked[r.s] = 0;
		end
		// all four at once: equal turns, then each drains
		foreach (nw[i]) nw[i] = 8'h6;
		go = 4'hf;
		@(posedge clk_sys) #1;
		go = 4'h0;
		for (int k = 0; k < 80 && sent.sum() < 8; k++)
			@(posedge clk_sys) #1;
		foreach (sent[i]) cmp("share", 2, sent[i]);
		wait_for(4'hf);
		foreach (acked[i]) cmp("drained", 8, acked[i]);
		// odd lanes may be split, even lanes not
		foreach (stride[i]) stride[i] = i % 2 ? 32'h8000_0000 >> i : '0;
		repeat (2) @(posedge clk_sys);
		#1;
		cmp("no_split", 4'h5, no_split);
		summarize();
	end
endmodule : output_stream_dma_interface_test

//--- skid_buffer.sv
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: synchronous active-high reset
// Notes:   full throughput; a stall downstream loses no word
`timescale 1ns/100ps
module skid_buffer #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst,
	// fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// drain side
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);
	logic [WIDTH-1:0] mem_reg [2];
	logic             wr_ptr_reg;
	logic             rd_ptr_reg;
	logic [1:0]       count_reg;
	logic             push;
	logic             pop;

	assign push      = in_valid && (count_reg != 2'h2);
	assign pop       = out_ready && (count_reg != 2'h0);
	assign in_ready  = (count_reg != 2'h2);
	assign out_valid = (count_reg != 2'h0);
	assign out_data  = mem_reg[rd_ptr_reg];

	// storage writes
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	// pointers and occupancy
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg  <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop) begin
				rd_ptr_reg <= ~rd_ptr_reg;
			end
			count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule : skid_buffer
